// ---- shared/sps_regs.vh ----
/*
 Constants for the supervisor pin logic: timing counts and watchdog period codes.
 Assumes a 10 MHz system clock; counts are derived from times in their own units.
*/
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// ----------------------------------------------------------------
// Clock and reset stretch
// ----------------------------------------------------------------
`define SPS_CLK_HZ            10000000
`define SPS_RST_STRETCH_MS    250
`define SPS_RST_STRETCH_CYC   ((`SPS_CLK_HZ / 1000) * `SPS_RST_STRETCH_MS)

// ----------------------------------------------------------------
// Watchdog period codes {hi,lo} and default periods in ms
// ----------------------------------------------------------------
`define SPS_WD_CODE_P0        2'b00
`define SPS_WD_CODE_P1        2'b01
`define SPS_WD_CODE_P2        2'b10
`define SPS_WD_CODE_OFF       2'b11
`define SPS_WD_P0_MS          1400
`define SPS_WD_P1_MS          600
`define SPS_WD_P2_MS          200
`define SPS_WD_P0_CYC         ((`SPS_CLK_HZ / 1000) * `SPS_WD_P0_MS)
`define SPS_WD_P1_CYC         ((`SPS_CLK_HZ / 1000) * `SPS_WD_P1_MS)
`define SPS_WD_P2_CYC         ((`SPS_CLK_HZ / 1000) * `SPS_WD_P2_MS)

// ----------------------------------------------------------------
// Serial framing and timer counter width
// ----------------------------------------------------------------
`define SPS_BITS_PER_BYTE     4'h8
`define SPS_CNT_W             25

`endif

// ---- hdl/sps_sync.v ----
/*
 Two flip-flop synchroniser for a group of pin inputs.
 Assumes the inputs are asynchronous to mclk_i; output is two edges late.
*/
`timescale 1ns/1ps

module sps_sync #(
   parameter W = 4
) (
   input  wire         mclk_i,
   input  wire         sys_rst_i,
   input  wire [W-1:0] async_i,
   input  wire [W-1:0] rst_val_i,
   output reg  [W-1:0] sync_o
);

   reg [W-1:0] stage1;

   // First stage feeds only the second; reset values come from constants at the
   // instance, and the reset is synchronous so no async load of a port occurs.
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stage1 <= rst_val_i;
         sync_o <= rst_val_i;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule // sps_sync

// ---- hdl/sps_supervisor.v ----
/*
 Pin logic of an SPI supervisor: select front end, mode 3 shifter, write-protect gate,
 watchdog restarted by select falling edges, and stretched open-drain reset output.
 Assumes the host is an SPI master with SCK far slower than mclk_i; the NV write
 engine, instruction decode and undervoltage comparator sit outside this block.
*/
// Notes on behaviour
// - Select high deselects the device and floats the serial output.
// - Select high means standby unless a nonvolatile write is still running.
// - No operation starts until a select falling edge is seen after power-up.
// - Each select falling edge restarts the watchdog count from zero.
// - No select falling edge within the timeout asserts reset; host must kick.
// - Serial output is push-pull and changes on each SCK falling edge.
// - Serial input is latched on each SCK rising edge.
// - Write-protect low refuses nonvolatile writes; high lets them proceed.
// - Reset output is active low, open drain, driven only when asserted.
// - Reset asserts at power-up and undervoltage, stretched 250ms after recovery.
// - Enabled watchdog asserts reset when select stays static past the timeout.
// - Timeout is chosen by two nonvolatile period bits kept across power loss.
// - Reset blocks serial traffic; undervoltage ends any transfer in progress.
`timescale 1ns/1ps
`include "sps_regs.vh"

module sps_supervisor #(
   parameter RST_STRETCH_CYC = `SPS_RST_STRETCH_CYC,
   parameter WD_P0_CYC       = `SPS_WD_P0_CYC,
   parameter WD_P1_CYC       = `SPS_WD_P1_CYC,
   parameter WD_P2_CYC       = `SPS_WD_P2_CYC
) (
   input  wire       mclk_i,
   input  wire       sys_rst_i,
   input  wire       select_and_watchdog_kick_pin_n_i,
   input  wire       sck_i,
   input  wire       si_i,
   input  wire       write_protect_n_i,
   input  wire       undervoltage_i,
   input  wire       watchdog_period_bit_hi_i,
   input  wire       watchdog_period_bit_lo_i,
   input  wire       nv_write_req_i,
   input  wire       nv_write_busy_i,
   input  wire [7:0] tx_byte_i,
   output reg  [7:0] rx_byte_o,
   output reg        rx_valid_o,
   output wire       tx_load_o,
   output reg        so_o,
   output wire       so_oe_o,
   output wire       nv_write_go_o,
   output wire       standby_o,
   output wire       frame_start_o,
   output wire       reset_n_o,
   output wire       reset_n_oe_o
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   wire [4:0] pin_s;
   sps_sync #(.W(5)) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({select_and_watchdog_kick_pin_n_i, sck_i, si_i,
                   write_protect_n_i, undervoltage_i}),
      .rst_val_i (5'h19),
      .sync_o    (pin_s)
   );
   wire cs_n = pin_s[4];
   wire sck  = pin_s[3];
   wire si   = pin_s[2];
   wire wp_n = pin_s[1];
   wire uv   = pin_s[0];

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   reg cs_n_d;
   reg sck_d;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cs_n_d <= 1'b1;
         // Matches the idle-high clock so no false edge follows reset
         sck_d  <= 1'b1;
      end else begin
         cs_n_d <= cs_n;
         sck_d  <= sck;
      end
   end
   wire cs_fall  = cs_n_d & ~cs_n;
   wire sck_rise = ~sck_d & sck;
   wire sck_fall = sck_d & ~sck;

   // ----------------------------------------------------------------
   // Reset generation and stretch
   // ----------------------------------------------------------------
   reg [`SPS_CNT_W-1:0] stretch_cnt;
   reg                  rst_active;
   reg [`SPS_CNT_W-1:0] wd_cnt;
   wire                 wd_expire;

   // Power-up enters with the counter loaded, so reset stands a full stretch
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stretch_cnt <= RST_STRETCH_CYC[`SPS_CNT_W-1:0];
         rst_active  <= 1'b1;
      end else if (uv || wd_expire) begin
         stretch_cnt <= RST_STRETCH_CYC[`SPS_CNT_W-1:0];
         rst_active  <= 1'b1;
      end else if (stretch_cnt != {`SPS_CNT_W{1'b0}}) begin
         stretch_cnt <= stretch_cnt - 1'b1;
         rst_active  <= 1'b1;
      end else begin
         rst_active  <= 1'b0;
      end
   end

   assign reset_n_o    = 1'b0;
   assign reset_n_oe_o = rst_active;

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   // Period bits live in NV storage outside; they are static so no sync needed
   wire [1:0] wd_code = {watchdog_period_bit_hi_i, watchdog_period_bit_lo_i};
   reg  [`SPS_CNT_W-1:0] wd_limit;
   always @* begin
      case (wd_code)
         `SPS_WD_CODE_P0: wd_limit = WD_P0_CYC[`SPS_CNT_W-1:0];
         `SPS_WD_CODE_P1: wd_limit = WD_P1_CYC[`SPS_CNT_W-1:0];
         `SPS_WD_CODE_P2: wd_limit = WD_P2_CYC[`SPS_CNT_W-1:0];
         default:         wd_limit = {`SPS_CNT_W{1'b0}};
      endcase
   end
   wire wd_enabled = (wd_code != `SPS_WD_CODE_OFF);

   // Count is held clear during reset so a fresh timeout follows release
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wd_cnt <= {`SPS_CNT_W{1'b0}};
      end else if (cs_fall || rst_active || !wd_enabled) begin
         wd_cnt <= {`SPS_CNT_W{1'b0}};
      end else if (wd_cnt < wd_limit) begin
         wd_cnt <= wd_cnt + 1'b1;
      end
   end
   assign wd_expire = wd_enabled && !rst_active && (wd_cnt >= wd_limit);

   // ----------------------------------------------------------------
   // Select front end
   // ----------------------------------------------------------------
   reg armed;
   reg active;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         armed  <= 1'b0;
         active <= 1'b0;
      end else if (rst_active) begin
         active <= 1'b0;
         armed  <= armed;
      end else if (cs_fall) begin
         armed  <= 1'b1;
         active <= 1'b1;
      end else if (cs_n) begin
         active <= 1'b0;
      end
   end
   assign frame_start_o = cs_fall & ~rst_active;
   assign standby_o     = cs_n & ~nv_write_busy_i;

   // ----------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------
   reg [7:0] rx_shift;
   reg [3:0] rx_cnt;
   reg [7:0] tx_shift;
   reg       first_bit;
   wire      shift_ok = active & armed & ~cs_n;

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_shift   <= 8'h00;
         rx_cnt     <= 4'h0;
         rx_byte_o  <= 8'h00;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (!shift_ok) begin
            rx_cnt <= 4'h0;
         end else if (sck_rise) begin
            rx_shift <= {rx_shift[6:0], si};
            if (rx_cnt == `SPS_BITS_PER_BYTE - 4'h1) begin
               rx_cnt     <= 4'h0;
               rx_byte_o  <= {rx_shift[6:0], si};
               rx_valid_o <= 1'b1;
            end else begin
               rx_cnt <= rx_cnt + 4'h1;
            end
         end
      end
   end

   // Next byte is loaded at the byte's last rising edge so falling edges shift it
   assign tx_load_o = shift_ok & sck_rise & (rx_cnt == `SPS_BITS_PER_BYTE - 4'h1);

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tx_shift  <= 8'h00;
         so_o      <= 1'b0;
         first_bit <= 1'b1;
      end else if (!shift_ok) begin
         first_bit <= 1'b1;
      end else if (tx_load_o) begin
         first_bit <= 1'b1;
      end else if (sck_fall) begin
         if (first_bit) begin
            so_o      <= tx_byte_i[7];
            tx_shift  <= {tx_byte_i[6:0], 1'b0};
            first_bit <= 1'b0;
         end else begin
            so_o     <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
         end
      end
   end
   // Push-pull while selected in a frame started outside reset; floats while deselected
   assign so_oe_o = shift_ok;

   // ----------------------------------------------------------------
   // Write-protect gate
   // ----------------------------------------------------------------
   assign nv_write_go_o = nv_write_req_i & wp_n & ~rst_active & armed;

endmodule // sps_supervisor

// ---- sim/sps_properties.sv ----
/* Checker bound to the supervisor pin logic; it sees only the block's ports.
 Assumes pins change at the falling clock edge. */
`timescale 1ns/1ps
module sps_props #(
   parameter RST_STRETCH_CYC = 100,
   parameter WD_P0_CYC       = 400,
   parameter WD_P1_CYC       = 300,
   parameter WD_P2_CYC       = 200
) (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire select_and_watchdog_kick_pin_n_i,
   input wire write_protect_n_i,
   input wire undervoltage_i,
   input wire watchdog_period_bit_hi_i,
   input wire watchdog_period_bit_lo_i,
   input wire rx_valid_o,
   input wire tx_load_o,
   input wire so_oe_o,
   input wire nv_write_go_o,
   input wire frame_start_o,
   input wire reset_n_o,
   input wire reset_n_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   wire        csn = select_and_watchdog_kick_pin_n_i;
   wire [31:0] lim = watchdog_period_bit_hi_i ? WD_P2_CYC : watchdog_period_bit_lo_i ? WD_P1_CYC : WD_P0_CYC;
   wire        wd_on = !(watchdog_period_bit_hi_i && watchdog_period_bit_lo_i);
   reg  [31:0] cnt;
   // Counted from the pin, so the bound below allows for the synchroniser
   always @(posedge mclk_i) begin
      cnt <= (sys_rst_i || reset_n_oe_o || !wd_on || $fell(csn)) ? 32'h0 : cnt + 32'h1;
   end
   oe_off_a: assert property (csn [*4] |-> !so_oe_o) else $error("SO driven");
   frame_go_a: assert property ($fell(csn) && !reset_n_oe_o |-> ##[2:4] frame_start_o)
      else $error("no frame start");
   stretch_a: assert property ($fell(reset_n_oe_o) |-> $past(reset_n_oe_o, RST_STRETCH_CYC))
      else $error("short reset");
   uv_rst_a: assert property ($rose(undervoltage_i) |-> ##[1:4] reset_n_oe_o)
      else $error("no undervoltage reset");
   od_low_a: assert property (reset_n_o == 1'b0) else $error("reset pin high");
   wp_block_a: assert property (!write_protect_n_i [*4] |-> !nv_write_go_o)
      else $error("write while protected");
   rx_after_a: assert property (rx_valid_o |-> $past(tx_load_o) && !reset_n_oe_o)
      else $error("stray byte");
   wd_fire_a: assert property (wd_on && !reset_n_oe_o |-> cnt <= lim + 32'd6)
      else $error("watchdog late");
   reg  [31:0] hold;
   // Cycles the reset has stood since the supply came back
   always @(posedge mclk_i) begin
      hold <= (sys_rst_i || undervoltage_i || !reset_n_oe_o) ? 32'h0 : hold + 32'h1;
   end
   stretch_full_a: assert property ($fell(reset_n_oe_o) |-> hold >= RST_STRETCH_CYC)
      else $error("reset stretch cut short");
   rst_block_a: assert property (reset_n_oe_o && $past(reset_n_oe_o)
      |-> !so_oe_o && !frame_start_o) else $error("traffic during reset");
endmodule // sps_props
bind sps_supervisor sps_props #(.RST_STRETCH_CYC(RST_STRETCH_CYC), .WD_P0_CYC(WD_P0_CYC),
   .WD_P1_CYC(WD_P1_CYC), .WD_P2_CYC(WD_P2_CYC)) u_sps_props (.mclk_i, .sys_rst_i,
   .select_and_watchdog_kick_pin_n_i, .write_protect_n_i, .undervoltage_i, .watchdog_period_bit_hi_i,
   .watchdog_period_bit_lo_i, .rx_valid_o, .tx_load_o, .so_oe_o, .nv_write_go_o, .frame_start_o,
   .reset_n_o, .reset_n_oe_o);

// ---- sim/sps_host.sv ----
/* Host model: SPI master in mode 3 on select, clock and data.
 Assumes calls start at a falling edge of the system clock. */
`timescale 1ns/1ps
module sps_host (
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      si_o = 1'b0;
   end
   task automatic frame(input logic sel, input logic [7:0] d, output logic [7:0] q);
      #800 cs_n_o = ~sel;
      #600;
      for (int i = 7; i >= 0; i--) begin
         #200 sck_o = 1'b0;
         si_o = d[i];
         #400 sck_o = 1'b1;
         // Late sample hides the pin synchroniser delay
         #200 q[i] = so_oe_i ? so_i : 1'bx;
      end
      #600 cs_n_o = 1'b1;
      si_o = ~si_o;
   endtask
endmodule // sps_host

// ---- sim/sps_supervisor_tb.sv ----
/* Self-checking bench for the supervisor pin logic.
 Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module sps_supervisor_tb;
   logic       mclk = 1'b0, sys_rst = 1'b1, wp_n = 1'b1, uv = 1'b0, req = 1'b0, busy = 1'b0;
   logic [1:0] code = 2'b11;
   logic [7:0] tx = 8'h00, d, q, exp_q[$];
   wire  [7:0] rx;
   wire        cs_n, sck, si, rx_v, ld, so, so_oe, go, stby, fs, rst_n, rst_oe;
   int         n_mismatch = 0, n_checks = 0, seed = 32'h9f2957ad;
   always #50 mclk = ~mclk;
   sps_host u_sps_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(so_oe));
   sps_supervisor #(.RST_STRETCH_CYC(100), .WD_P0_CYC(400), .WD_P1_CYC(300), .WD_P2_CYC(200))
   u_sps_supervisor (.mclk_i(mclk), .sys_rst_i(sys_rst), .select_and_watchdog_kick_pin_n_i(cs_n),
      .sck_i(sck), .si_i(si), .write_protect_n_i(wp_n), .undervoltage_i(uv),
      .watchdog_period_bit_hi_i(code[1]), .watchdog_period_bit_lo_i(code[0]),
      .nv_write_req_i(req), .nv_write_busy_i(busy), .tx_byte_i(tx), .rx_byte_o(rx),
      .rx_valid_o(rx_v), .tx_load_o(ld), .so_o(so), .so_oe_o(so_oe), .nv_write_go_o(go),
      .standby_o(stby), .frame_start_o(fs), .reset_n_o(rst_n), .reset_n_oe_o(rst_oe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) n_mismatch++;
      if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic stop_test;
      chk(8'(exp_q.size()), 8'h00);
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wait_rst(input logic v, input int n);
      for (int k = 0; k < n && rst_oe !== v; k++) @(negedge mclk);
      chk({7'h0, rst_oe}, {7'h0, v});
      if (rst_oe !== v) stop_test;
   endtask
   task automatic xfer(input logic sel);
      {d, tx} = 16'($random(seed));
      if (sel) exp_q.push_back(d);
      u_sps_host.frame(sel, d, q);
      chk(q, sel ? tx : 8'hxx);
   endtask
   always @(negedge mclk)
      if (rx_v === 1'b1) chk(rx, exp_q.size() ? exp_q.pop_front() : 8'hxx);
   initial begin
      repeat (6) @(negedge mclk);
      sys_rst = 1'b0;
      u_sps_host.frame(1'b1, 8'ha5, q);
      wait_rst(1'b0, 200);
      xfer(1'b0);
      busy = 1'b1;
      #400 chk({7'h0, stby}, 8'h00);
      busy = 1'b0;
      #100 chk({7'h0, stby}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         code = c[1:0];
         xfer(1'b1);
         repeat (c == 3 ? 500 : 290 - 100 * c) @(negedge mclk);
         chk({7'h0, rst_oe}, 8'h00);
         if (c < 3) wait_rst(1'b1, 60);
         wait_rst(1'b0, 150);
      end
      {req, wp_n} = 2'b10;
      #500 chk({7'h0, go}, 8'h00);
      wp_n = 1'b1;
      #500 chk({7'h0, go}, 8'h01);
      {req, uv} = 2'b01;
      wait_rst(1'b1, 6);
      uv = 1'b0;
      #9000 chk({7'h0, rst_oe}, 8'h01);
      wait_rst(1'b0, 30);
      stop_test;
   end
endmodule // sps_supervisor_tb
